//--- common/scc_pkg.sv
// Constants for the system clock select, suspend and wake block
package scc_pkg;
   // Register offsets
   localparam logic [7:0] OFF_CAN_CFG = 8'h92;
   localparam logic [7:0] OFF_SYSCLK_SEL = 8'h8f;
   localparam logic [7:0] OFF_INT_CTL = 8'h90;
   localparam logic [7:0] OFF_COARSE = 8'h91;
   localparam logic [7:0] OFF_FINE = 8'h93;
   localparam logic [7:0] OFF_EXT_CTL = 8'h94;
   localparam logic [7:0] OFF_MULT_CTL = 8'h95;
   localparam logic [3:0][7:0] OFF_PMAT = {8'hf7, 8'hf5, 8'hf3, 8'hf1};
   localparam logic [3:0][7:0] OFF_PMSK = {8'hf8, 8'hf6, 8'hf4, 8'hf2};
   // Field positions
   localparam int INT_EN_BIT = 7;
   localparam int SUSPEND_BIT = 5;
   localparam int EXT_VALID_BIT = 7;
   localparam int EXT_EN_BIT = 6;
   localparam int EXT_XTAL_BIT = 4;
   localparam int MULT_EN_BIT = 7;
   localparam int MULT_RDY_BIT = 6;
   localparam int MULT_X4_BIT = 4;
   // Selector codes and reset values
   localparam logic [1:0] SEL_INT = 2'h0;
   localparam logic [1:0] SEL_EXT = 2'h1;
   localparam logic [1:0] SEL_MUL = 2'h2;
   localparam logic [2:0] IDIV_RST = 3'h7;
   localparam logic [7:0] COARSE_RST = 8'h40;
   localparam logic [7:0] FINE_RST = 8'h20;
   localparam logic [7:0] PMAT_RST = 8'hff;
   localparam logic [7:0] PMSK_RST = 8'h00;
   localparam logic [1:0] CAN_DIV_RST = 2'h0;
   // Crystal settle count in external clock edges
   localparam int XTAL_VALID_EDGES = 1024;
   localparam logic [2:0] MSCALE_MAX = 3'h5;
   typedef enum logic [2:0] {
      SRC_INT = 3'b001,
      SRC_EXT = 3'b010,
      SRC_MUL = 3'b100
   } scc_src_t;
endpackage : scc_pkg

//--- common/scc_match_if.sv
// Port pins, compare settings and mismatch results between modules
`timescale 1ns/1ps
interface scc_match_if;
   logic [7:0] pins [4];
   logic [7:0] mask [4];
   logic [7:0] expect_v [4];
   logic [3:0] mismatch;
   modport src (output pins, output mask, output expect_v,
      input mismatch);
   modport det (input pins, input mask, input expect_v,
      output mismatch);
endinterface : scc_match_if

//--- hdl/scc_port_match.sv
// Per-port pattern mismatch detector for ports 0 to 3
`timescale 1ns/1ps
module scc_port_match (
   scc_match_if.det mi
);
   import scc_pkg::*;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_port
         // Masked-off pins never contribute
         assign mi.mismatch[g] =
            |((mi.pins[g] ^ mi.expect_v[g]) & mi.mask[g]);
      end
   endgenerate
endmodule : scc_port_match

//--- hdl/scc_top.sv
// System clock source select, suspend, port wake and CAN clock divide
`timescale 1ns/1ps
module scc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [31:0] port_pins,
   input wire logic cmp0_enable,
   input wire logic cmp0_out,
   input wire logic ext_osc_clk,
   input wire logic mult_base_tick,
   input wire logic mult_lock,
   output logic sysclk_tick,
   output logic can_clk_tick,
   output logic ext_periph_tick,
   output logic core_halt,
   output logic port_match_evt,
   output logic wake_evt,
   output logic int_osc_run,
   output logic [7:0] osc_coarse_trim,
   output logic [7:0] osc_fine_trim,
   output logic ext_osc_enable,
   output logic ext_xtal_mode,
   output logic mult_enable,
   output logic mult_x4_sel
);
   import scc_pkg::*;

   scc_match_if mi ();

   logic [1:0] src_sel_r;
   logic int_en_r;
   logic suspend_r;
   logic [2:0] idiv_r;
   logic [7:0] coarse_r;
   logic [7:0] fine_r;
   logic ext_en_r;
   logic xtal_mode_r;
   logic xtal_valid_r;
   logic [10:0] xtal_cnt_r;
   logic mult_en_r;
   logic mult_x4_r;
   logic [2:0] mscale_r;
   logic [2:0] macc_r;
   logic [2:0] macc_nxt;
   logic [1:0] can_div_r;
   logic [2:0] can_cnt_r;
   logic [6:0] idiv_cnt_r;
   logic [7:0] pmat_r [4];
   logic [7:0] pmsk_r [4];
   logic [7:0] pin_s1_r [4];
   logic [7:0] pin_s2_r [4];
   logic cmp_s1_r;
   logic cmp_s2_r;
   logic eclk_s1_r;
   logic eclk_s2_r;
   logic eclk_s3_r;
   logic lock_s1_r;
   logic lock_s2_r;
   logic match_evt_r;
   logic wake_r;
   logic [7:0] rdata_r;
   scc_src_t active_r;
   scc_src_t req_src;

   // Address decode
   wire wr_sel = sfr_wr && (sfr_addr == OFF_SYSCLK_SEL);
   wire wr_int = sfr_wr && (sfr_addr == OFF_INT_CTL);
   wire wr_crs = sfr_wr && (sfr_addr == OFF_COARSE);
   wire wr_fin = sfr_wr && (sfr_addr == OFF_FINE);
   wire wr_ext = sfr_wr && (sfr_addr == OFF_EXT_CTL);
   wire wr_mul = sfr_wr && (sfr_addr == OFF_MULT_CTL);
   wire wr_can = sfr_wr && (sfr_addr == OFF_CAN_CFG);

   // Pins sampled through two flops before any use
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_port
         always_ff @(posedge clk) begin
            pin_s1_r[g] <= port_pins[8*g +: 8];
            pin_s2_r[g] <= pin_s1_r[g];
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               pmat_r[g] <= PMAT_RST;
               pmsk_r[g] <= PMSK_RST;
            end else begin
               if (sfr_wr && sfr_addr == OFF_PMAT[g])
                  pmat_r[g] <= sfr_wdata;
               if (sfr_wr && sfr_addr == OFF_PMSK[g])
                  pmsk_r[g] <= sfr_wdata;
            end
         end
         // Raw pins, not crossbar outputs
         assign mi.pins[g] = pin_s2_r[g];
         assign mi.mask[g] = pmsk_r[g];
         assign mi.expect_v[g] = pmat_r[g];
      end
   endgenerate

   scc_port_match u_match (
      .mi(mi.det)
   );

   always_ff @(posedge clk) begin
      cmp_s1_r <= cmp0_out;
      cmp_s2_r <= cmp_s1_r;
      eclk_s1_r <= ext_osc_clk;
      eclk_s2_r <= eclk_s1_r;
      eclk_s3_r <= eclk_s2_r;
      lock_s1_r <= mult_lock;
      lock_s2_r <= lock_s1_r;
   end

   // Wake sources
   wire any_mismatch = |mi.mismatch;
   wire cmp_wake = cmp0_enable && !cmp_s2_r;
   wire wake_src = any_mismatch || cmp_wake;

   // Oscillator state and ready terms
   assign int_osc_run = int_en_r && !suspend_r;
   wire ext_edge = eclk_s2_r && !eclk_s3_r;
   wire ext_rdy = ext_en_r && (!xtal_mode_r || xtal_valid_r);
   wire mul_rdy = mult_en_r && lock_s2_r && int_osc_run;

   // Internal divider: tick when the low idiv bits are all ones
   wire [6:0] idiv_mask = 7'((8'h01 << idiv_r) - 8'h01);
   wire int_tick = int_osc_run &&
      ((idiv_cnt_r & idiv_mask) == idiv_mask);

   // Multiplier scaling by 2/n, n = code + 2, for codes 1 to 5; codes 0, 6 and 7 scale by one
   wire mul_in = mult_base_tick && mult_en_r && int_osc_run;
   wire [2:0] mul_n = mscale_r + 3'h2;
   // Spare bit: residue 6 plus 2 must not wrap to zero
   wire [3:0] macc_sum = {1'b0, macc_r} + 4'h2;
   wire [3:0] mul_n4 = {1'b0, mul_n};
   wire mscale_one = (mscale_r == 3'h0) || (mscale_r > MSCALE_MAX);
   wire mul_wrap = macc_sum >= mul_n4;
   wire mul_tick = mul_in && (mscale_one || mul_wrap);
   wire [3:0] macc_rem = macc_sum - mul_n4;
   assign macc_nxt = mul_wrap ? macc_rem[2:0] : macc_sum[2:0];

   // Requested source and its readiness
   always_comb begin
      unique case (src_sel_r)
         SEL_EXT: req_src = SRC_EXT;
         SEL_MUL: req_src = SRC_MUL;
         default: req_src = SRC_INT;
      endcase
   end

   logic req_rdy;
   logic cur_tick;
   logic cur_run;
   always_comb begin
      unique case (req_src)
         SRC_INT: req_rdy = int_osc_run;
         SRC_EXT: req_rdy = ext_rdy;
         SRC_MUL: req_rdy = mul_rdy;
         default: req_rdy = 1'b0;
      endcase
      unique case (active_r)
         SRC_INT: begin
            cur_tick = int_tick;
            cur_run = int_osc_run;
         end
         SRC_EXT: begin
            cur_tick = ext_edge;
            cur_run = ext_en_r;
         end
         SRC_MUL: begin
            cur_tick = mul_tick;
            cur_run = mul_rdy;
         end
         default: begin
            cur_tick = 1'b0;
            cur_run = 1'b0;
         end
      endcase
   end

   // Change on a finished period of the old source, or at once if the old source is not running
   wire do_switch = (req_src != active_r) && req_rdy &&
      (cur_tick || !cur_run);

   always_ff @(posedge clk) begin
      if (rst)
         active_r <= SRC_INT;
      else if (do_switch)
         active_r <= req_src;
   end

   assign sysclk_tick = cur_tick;
   assign ext_periph_tick = ext_edge;
   // Core held in place during suspend unless the external source is active, so it resumes at the next instruction
   assign core_halt = suspend_r && (active_r != SRC_EXT);

   // CAN clock divider over system clock ticks
   wire [2:0] can_mask = 3'((4'h1 << can_div_r) - 4'h1);
   assign can_clk_tick = sysclk_tick &&
      ((can_cnt_r & can_mask) == can_mask);

   always_ff @(posedge clk) begin
      if (rst) begin
         idiv_cnt_r <= 7'h00;
         can_cnt_r <= 3'h0;
         macc_r <= 3'h0;
      end else begin
         if (int_osc_run)
            idiv_cnt_r <= idiv_cnt_r + 7'h01;
         if (sysclk_tick)
            can_cnt_r <= can_cnt_r + 3'h1;
         if (mul_in && !mscale_one)
            macc_r <= macc_nxt;
      end
   end

   // Control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         src_sel_r <= SEL_INT;
         int_en_r <= 1'b1;
         idiv_r <= IDIV_RST;
         coarse_r <= COARSE_RST;
         fine_r <= FINE_RST;
         ext_en_r <= 1'b0;
         xtal_mode_r <= 1'b0;
         mult_en_r <= 1'b0;
         mult_x4_r <= 1'b0;
         mscale_r <= 3'h0;
         can_div_r <= CAN_DIV_RST;
      end else begin
         if (wr_sel)
            src_sel_r <= sfr_wdata[1:0];
         if (wr_int) begin
            int_en_r <= sfr_wdata[INT_EN_BIT];
            idiv_r <= sfr_wdata[2:0];
         end
         if (wr_crs)
            coarse_r <= sfr_wdata;
         if (wr_fin)
            fine_r <= sfr_wdata;
         if (wr_ext) begin
            ext_en_r <= sfr_wdata[EXT_EN_BIT];
            xtal_mode_r <= sfr_wdata[EXT_XTAL_BIT];
         end
         if (wr_mul) begin
            mult_en_r <= sfr_wdata[MULT_EN_BIT];
            mult_x4_r <= sfr_wdata[MULT_X4_BIT];
            mscale_r <= sfr_wdata[2:0];
         end
         if (wr_can)
            can_div_r <= sfr_wdata[1:0];
      end
   end

   // Suspend: a wake in the same cycle as the write wins
   always_ff @(posedge clk) begin
      if (rst)
         suspend_r <= 1'b0;
      else if (wake_src)
         suspend_r <= 1'b0;
      else if (wr_int && sfr_wdata[SUSPEND_BIT])
         suspend_r <= 1'b1;
   end

   // Crystal settle counter on external edges
   always_ff @(posedge clk) begin
      if (rst || !ext_en_r) begin
         xtal_cnt_r <= 11'h000;
         xtal_valid_r <= 1'b0;
      end else if (ext_edge && !xtal_valid_r) begin
         xtal_cnt_r <= xtal_cnt_r + 11'h001;
         if (xtal_cnt_r == 11'(XTAL_VALID_EDGES - 1))
            xtal_valid_r <= 1'b1;
      end
   end

   // Mismatch drives both interrupt and wake outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         match_evt_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         match_evt_r <= any_mismatch;
         wake_r <= wake_src;
      end
   end
   assign port_match_evt = match_evt_r;
   assign wake_evt = wake_r;

   // Read side
   logic [7:0] port_rd [4];
   generate
      for (g = 0; g < 4; g++) begin : g_rd
         assign port_rd[g] = (sfr_addr == OFF_PMAT[g]) ? pmat_r[g] :
            (sfr_addr == OFF_PMSK[g]) ? pmsk_r[g] : 8'h00;
      end
   endgenerate
   wire [7:0] port_rd_all = port_rd[0] | port_rd[1] | port_rd[2] |
      port_rd[3];
   wire [7:0] sel_rd = {2'h0, active_r == SRC_MUL, active_r == SRC_EXT,
      2'h0, src_sel_r};
   wire [7:0] int_rd = {int_en_r, int_osc_run, suspend_r, 2'h0, idiv_r};
   wire [7:0] ext_rd = {xtal_valid_r, ext_en_r, 1'b0, xtal_mode_r, 4'h0};
   wire [7:0] mul_rd = {mult_en_r, mul_rdy, 1'b0, mult_x4_r, 1'b0,
      mscale_r};
   wire [7:0] rd_mux =
      (sfr_addr == OFF_SYSCLK_SEL) ? sel_rd :
      (sfr_addr == OFF_INT_CTL) ? int_rd :
      (sfr_addr == OFF_COARSE) ? coarse_r :
      (sfr_addr == OFF_FINE) ? fine_r :
      (sfr_addr == OFF_EXT_CTL) ? ext_rd :
      (sfr_addr == OFF_MULT_CTL) ? mul_rd :
      (sfr_addr == OFF_CAN_CFG) ? {6'h00, can_div_r} : port_rd_all;

   always_ff @(posedge clk) begin
      if (rst)
         rdata_r <= 8'h00;
      else if (sfr_rd)
         rdata_r <= rd_mux;
   end
   assign sfr_rdata = rdata_r;

   assign osc_coarse_trim = coarse_r;
   assign osc_fine_trim = fine_r;
   assign ext_osc_enable = ext_en_r;
   assign ext_xtal_mode = xtal_mode_r;
   assign mult_enable = mult_en_r;
   assign mult_x4_sel = mult_x4_r;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_ext_sel;
      $changed(active_r) && active_r == SRC_EXT |->
         $past(src_sel_r) == SEL_EXT;
   endproperty
   a_ext_sel: assert property (p_ext_sel)
      else $error("external source taken without selector 01");

   property p_rst_int;
      $past(rst) |-> active_r == SRC_INT && idiv_r == IDIV_RST;
   endproperty
   a_rst_int: assert property (@(posedge clk) p_rst_int)
      else $error("reset did not pick internal source at div 128");

   property p_int_fast;
      active_r == SRC_INT && int_osc_run && idiv_r == 3'h0 |->
         sysclk_tick;
   endproperty
   a_int_fast: assert property (p_int_fast)
      else $error("internal source not ticking without divider");

   sequence s_div2_tick;
      int_tick && idiv_r == 3'h1 && !wr_int;
   endsequence
   property p_div2;
      s_div2_tick ##1 int_osc_run |-> !int_tick ##1
         (int_tick || !int_osc_run || $changed(idiv_r));
   endproperty
   a_div2: assert property (p_div2)
      else $error("divide by 2 period wrong");

   property p_xtal;
      $rose(xtal_valid_r) |-> ext_en_r &&
         $past(xtal_cnt_r) == 11'(XTAL_VALID_EDGES - 1);
   endproperty
   a_xtal: assert property (p_xtal)
      else $error("crystal valid set before settle count");

   property p_halt;
      suspend_r && active_r == SRC_INT |-> !sysclk_tick && core_halt;
   endproperty
   a_halt: assert property (p_halt)
      else $error("internal clock ran during suspend");

   property p_wake;
      suspend_r && wake_src |=> !suspend_r && wake_evt;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake event did not end suspend");

   property p_can;
      can_div_r == 2'h0 |-> can_clk_tick == sysclk_tick;
   endproperty
   a_can: assert property (p_can)
      else $error("CAN clock not equal to system clock at div 1");

   property p_switch;
      $changed(active_r) |-> $past(cur_tick || !cur_run);
   endproperty
   a_switch: assert property (p_switch)
      else $error("source switched mid period");

   property p_match;
      any_mismatch |=> port_match_evt;
   endproperty
   a_match: assert property (p_match)
      else $error("mismatch did not raise event");
endmodule : scc_top

//--- tb/scc_far_model.sv
// Far side: external oscillator, multiplier base, port pins, comparator
`timescale 1ns/1ps
module scc_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_osc_enable,
   input wire logic mult_enable,
   input wire logic [31:0] pin_drive,
   input wire logic cmp_drive,
   output logic ext_osc_clk,
   output logic mult_base_tick,
   output logic mult_lock,
   output logic [31:0] port_pins,
   output logic cmp0_out
);
   logic [4:0] lock_cnt_r;
   // Oscillator stands still while disabled, period unrelated to clk
   initial begin
      ext_osc_clk = 1'b0;
      forever begin
         #130;
         ext_osc_clk = (ext_osc_enable === 1'b1) ? ~ext_osc_clk : 1'b0;
      end
   end
   // Lock only after a settling count; lost at once on disable
   always @(posedge clk) begin
      if (rst || !mult_enable) begin
         lock_cnt_r <= 5'h00;
      end else if (lock_cnt_r != 5'h10) begin
         lock_cnt_r <= lock_cnt_r + 5'h01;
      end
   end
   assign mult_lock = (lock_cnt_r == 5'h10);
   assign mult_base_tick = mult_lock;
   assign port_pins = pin_drive;
   assign cmp0_out = cmp_drive;
endmodule : scc_far_model

//--- tb/scc_top_tb_top.sv
// Self-checking bench for the clock select, suspend and wake block
`timescale 1ns/1ps
module scc_top_tb_top;
   import scc_pkg::*;
   logic clk, rst, sfr_wr, sfr_rd, cmp0_enable, cmp_drive, cmp0_out;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [31:0] pin_drive, port_pins;
   logic ext_osc_clk, mult_base_tick, mult_lock, sysclk_tick, can_clk_tick;
   logic ext_periph_tick, core_halt, port_match_evt, wake_evt, int_osc_run;
   logic [7:0] osc_coarse_trim, osc_fine_trim;
   logic ext_osc_enable, ext_xtal_mode, mult_enable, mult_x4_sel;
   logic zero_tc_bias_enable;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int n, s, c, e;

   scc_top DUT (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .port_pins(port_pins), .cmp0_enable(cmp0_enable),
      .cmp0_out(cmp0_out), .ext_osc_clk(ext_osc_clk),
      .mult_base_tick(mult_base_tick), .mult_lock(mult_lock),
      .sysclk_tick(sysclk_tick), .can_clk_tick(can_clk_tick),
      .ext_periph_tick(ext_periph_tick), .core_halt(core_halt),
      .port_match_evt(port_match_evt), .wake_evt(wake_evt),
      .int_osc_run(int_osc_run), .osc_coarse_trim(osc_coarse_trim),
      .osc_fine_trim(osc_fine_trim), .ext_osc_enable(ext_osc_enable),
      .ext_xtal_mode(ext_xtal_mode), .mult_enable(mult_enable),
      .mult_x4_sel(mult_x4_sel));

   scc_far_model far (.clk(clk), .rst(rst), .ext_osc_enable(ext_osc_enable),
      .mult_enable(mult_enable), .pin_drive(pin_drive),
      .cmp_drive(cmp_drive), .ext_osc_clk(ext_osc_clk),
      .mult_base_tick(mult_base_tick), .mult_lock(mult_lock),
      .port_pins(port_pins), .cmp0_out(cmp0_out));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Tick counts depend on divider phase, so allow a small slack
   task automatic near(input int got, input int exp, input int tol);
      n_checks++;
      if (got > exp + tol || got < exp - tol) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : near

   task automatic cycles(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cycles

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk);
      #1;
      sfr_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk);
      #1;
      sfr_rd = 1'b0;
      chk({8'h00, sfr_rdata}, {8'h00, exp});
   endtask : rd

   // Sampled at the falling edge, where the tick outputs have settled
   task automatic count(input int k, output int ns, output int nc,
      output int ne);
      ns = 0;
      nc = 0;
      ne = 0;
      repeat (k) begin
         @(negedge clk);
         if (sysclk_tick === 1'b1) ns++;
         if (can_clk_tick === 1'b1) nc++;
         if (ext_periph_tick === 1'b1) ne++;
      end
      #51;
   endtask : count

   task automatic wait_wake();
      int i;
      for (i = 0; i < 20 && wake_evt !== 1'b1; i++) @(negedge clk);
      chk(16'(wake_evt), 16'h0001);
      #51;
   endtask : wait_wake

   task automatic reset_tab();
      int i;
      rd(OFF_SYSCLK_SEL, 8'h00);
      rd(OFF_INT_CTL, 8'hc7);
      rd(OFF_COARSE, COARSE_RST);
      rd(OFF_FINE, FINE_RST);
      chk({osc_coarse_trim, osc_fine_trim}, {COARSE_RST, FINE_RST});
      rd(OFF_CAN_CFG, 8'h00);
      rd(8'h80, 8'h00);
      for (i = 0; i < 4; i++) begin
         rd(OFF_PMAT[i], PMAT_RST);
         rd(OFF_PMSK[i], PMSK_RST);
      end
   endtask : reset_tab

   initial begin
      rst = 1'b1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      pin_drive = 32'hffffffff;
      cmp0_enable = 1'b0;
      cmp_drive = 1'b1;
      zero_tc_bias_enable = 1'b0;
      cycles(6);
      rst = 1'b0;
      reset_tab();
      wr(8'h80, 8'h5a);
      rd(8'h80, 8'h00);
      for (n = 0; n < 8; n++) begin
         wr(OFF_INT_CTL, 8'h80 | 8'(n));
         cycles(4);
         count(256, s, c, e);
         near(s, 256 >> n, 1);
      end
      wr(OFF_INT_CTL, 8'h80);
      wr(OFF_CAN_CFG, 8'hff);
      rd(OFF_CAN_CFG, 8'h03);
      // Divide by one keeps the CAN clock at the system rate, below 25 MHz
      for (n = 0; n < 4; n++) begin
         wr(OFF_CAN_CFG, 8'(n));
         cycles(4);
         count(64, s, c, e);
         near(c, 64 >> n, 1);
      end
      for (n = 0; n < 4; n++) begin
         wr(OFF_PMSK[n], 8'h0f);
         wr(OFF_PMAT[n], 8'h05);
         rd(OFF_PMAT[n], 8'h05);
         pin_drive[8*n +: 8] = 8'hf5;
         cycles(6);
         chk(16'(port_match_evt), 16'h0000);
         pin_drive[8*n +: 8] = 8'h05;
         cycles(6);
         chk(16'(port_match_evt), 16'h0000);
         pin_drive[8*n +: 8] = 8'hf4;
         cycles(6);
         chk(16'(port_match_evt), 16'h0001);
         wr(OFF_PMSK[n], 8'h00);
         pin_drive[8*n +: 8] = 8'hff;
         cycles(6);
      end
      wr(OFF_PMSK[0], 8'h01);
      zero_tc_bias_enable = 1'b1;
      wr(OFF_INT_CTL, 8'ha0);
      cycles(2);
      chk(16'(int_osc_run), 16'h0000);
      chk(16'(core_halt), 16'h0001);
      pin_drive[0] = 1'b0;
      wait_wake();
      cycles(2);
      chk(16'(int_osc_run), 16'h0001);
      chk(16'(core_halt), 16'h0000);
      chk(16'(port_match_evt), 16'h0001);
      pin_drive[0] = 1'b1;
      wr(OFF_PMSK[0], 8'h00);
      cycles(4);
      wr(OFF_INT_CTL, 8'ha0);
      cycles(2);
      chk(16'(core_halt), 16'h0001);
      cmp0_enable = 1'b1;
      cmp_drive = 1'b0;
      wait_wake();
      cycles(2);
      chk(16'(core_halt), 16'h0000);
      cmp0_enable = 1'b0;
      cmp_drive = 1'b1;
      cycles(4);
      // Crystal not yet settled: the request must wait, not switch
      wr(OFF_EXT_CTL, 8'h50);
      chk(16'({ext_osc_enable, ext_xtal_mode}), 16'h0003);
      wr(OFF_SYSCLK_SEL, 8'h01);
      cycles(100);
      rd(OFF_SYSCLK_SEL, 8'h01);
      count(200, s, c, e);
      near(s, 200, 1);
      chk(16'(e > 50), 16'h0001);
      cycles(10000);
      rd(OFF_EXT_CTL, 8'hd0);
      cycles(4);
      rd(OFF_SYSCLK_SEL, 8'h11);
      count(500, s, c, e);
      near(s, e, 1);
      wr(OFF_MULT_CTL, 8'h80);
      cycles(40);
      rd(OFF_MULT_CTL, 8'hc0);
      wr(OFF_SYSCLK_SEL, 8'h02);
      cycles(6);
      rd(OFF_SYSCLK_SEL, 8'h22);
      for (n = 0; n < 6; n++) begin
         wr(OFF_MULT_CTL, 8'h80 | 8'(n));
         cycles(8);
         count(420, s, c, e);
         near(s, (n == 0) ? 420 : 840 / (n + 2), 2);
      end
      wr(OFF_MULT_CTL, 8'h90);
      rd(OFF_MULT_CTL, 8'hd0);
      chk(16'({mult_enable, mult_x4_sel}), 16'h0003);
      rst = 1'b1;
      cycles(6);
      rst = 1'b0;
      reset_tab();
      count(256, s, c, e);
      near(s, 2, 1);
      final_report();
   end
endmodule : scc_top_tb_top
